// file: design/uefc_device.sv
`timescale 1ns/1ps
`include "uefc_defs.svh"
module uefc_device (
  input wire logic clock_in,
  input wire logic rst_in,
  uefc_if.dev bus,
  input wire logic clk_ok_in,
  input wire logic rx_start_in,
  input wire logic [1:0] rx_ep_in,
  input wire logic rx_byte_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_end_in,
  input wire logic rx_crc_ok_in,
  output logic hs_ack_out,
  output logic hs_nak_out,
  output logic rx_irq_out
);
  localparam int NEP = `UEFC_NEP;
  localparam int DEPTH = `UEFC_DEPTH;
  localparam logic [NEP-1:0] PP_MASK = `UEFC_PP_MASK;

  logic [1:0] sel_ff;
  logic [NEP-1:0][7:0] cfg_ff;
  logic [7:0] freset_ff;
  logic [NEP-1:0] irqen_ff;
  logic [NEP-1:0][1:0] flag_ff;
  logic [NEP-1:0] fill_ff;
  logic [NEP-1:0] rdb_ff;
  logic [NEP-1:0][1:0][7:0] cnt_ff;
  logic [NEP-1:0][3:0] fptr_ff;
  logic [7:0] mem [0:NEP*2*DEPTH-1];
  logic [7:0] rdata_ff;
  logic irq_ff;
  logic hs_ack_ff;
  logic hs_nak_ff;
  logic clk_ok_meta_ff;
  logic clk_ok_ff;
  uefc_pkg::uefc_rx_state_t rx_state_ff;
  logic [1:0] rx_ep_ff;
  logic rx_bank_ff;
  logic [4:0] wptr_ff;
  logic [7:0] rcnt_ff;

  logic [NEP-1:0] pp_mode;
  logic [NEP-1:0] is_in;
  logic wr_sel, wr_cfg, wr_stat, wr_data, wr_frst, wr_ie, rd_data;
  logic [1:0] clr_bank;
  logic commit;
  logic [6:0] fw_idx;
  logic st_en, st_out_ok, st_busy, st_bank;
  logic rd_bank;
  logic [7:0] rd_mux;

  // Ping-pong only for listed endpoints and never for control type
  always_comb begin
    for (int e = 0; e < NEP; e++) begin
      pp_mode[e] = PP_MASK[e] && (cfg_ff[e][1:0] != uefc_pkg::UEFC_TYPE_CONTROL);
      is_in[e] = (cfg_ff[e][1:0] != uefc_pkg::UEFC_TYPE_CONTROL) && cfg_ff[e][`UEFC_B_DIR];
    end
  end

  always_comb begin
    wr_sel = 1'b0;
    wr_cfg = 1'b0;
    wr_stat = 1'b0;
    wr_data = 1'b0;
    wr_frst = 1'b0;
    wr_ie = 1'b0;
    if (bus.reg_wr && bus.reg_addr == `UEFC_A_SELECT) begin
      wr_sel = 1'b1;
    end else if (bus.reg_wr && bus.reg_addr == `UEFC_A_CONFIG) begin
      wr_cfg = 1'b1;
    end else if (bus.reg_wr && bus.reg_addr == `UEFC_A_STATUS) begin
      wr_stat = 1'b1;
    end else if (bus.reg_wr && bus.reg_addr == `UEFC_A_DATA) begin
      wr_data = is_in[sel_ff] || (cfg_ff[sel_ff][1:0] == uefc_pkg::UEFC_TYPE_CONTROL);
    end else if (bus.reg_wr && bus.reg_addr == `UEFC_A_FRESET) begin
      wr_frst = 1'b1;
    end else if (bus.reg_wr && bus.reg_addr == `UEFC_A_IRQEN) begin
      wr_ie = 1'b1;
    end
    rd_data = bus.reg_rd && bus.reg_addr == `UEFC_A_DATA && !is_in[sel_ff];
    // Writing zero to a set flag releases that bank; the bank 1 flag is released only in ping-pong mode
    clr_bank[0] = wr_stat && !bus.reg_wdata[`UEFC_B_RX0] && flag_ff[sel_ff][0];
    clr_bank[1] = wr_stat && !bus.reg_wdata[`UEFC_B_RX1] && flag_ff[sel_ff][1] && pp_mode[sel_ff];
  end

  // Single-bank endpoints always read bank 0, whatever bank number was left over
  assign rd_bank = pp_mode[sel_ff] && rdb_ff[sel_ff];
  assign fw_idx = {sel_ff, rd_bank, fptr_ff[sel_ff]};
  assign commit = rx_state_ff == uefc_pkg::UEFC_RX_RECV && rx_end_in && rx_crc_ok_in;

  // Acceptance check for a new OUT token
  always_comb begin
    st_en = cfg_ff[rx_ep_in][`UEFC_B_ENABLE];
    st_out_ok = !is_in[rx_ep_in];
    if (pp_mode[rx_ep_in]) begin
      st_bank = flag_ff[rx_ep_in][fill_ff[rx_ep_in]] ? !fill_ff[rx_ep_in] : fill_ff[rx_ep_in];
      st_busy = &flag_ff[rx_ep_in];
    end else begin
      st_bank = 1'b0;
      st_busy = flag_ff[rx_ep_in][0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      clk_ok_meta_ff <= 1'b0;
      clk_ok_ff <= 1'b0;
    end else begin
      clk_ok_meta_ff <= clk_ok_in;
      clk_ok_ff <= clk_ok_meta_ff;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sel_ff <= 2'h0;
      freset_ff <= 8'h00;
      irqen_ff <= '0;
    end else begin
      if (wr_sel) begin
        sel_ff <= bus.reg_wdata[1:0];
      end
      if (wr_frst) begin
        freset_ff <= bus.reg_wdata;
      end
      if (wr_ie) begin
        irqen_ff <= bus.reg_wdata[NEP-1:0];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg_ff <= '0;
    end else begin
      for (int e = 0; e < NEP; e++) begin
        if (freset_ff[e]) begin
          cfg_ff[e][`UEFC_B_TOGGLE] <= 1'b0;
        end else if (commit && rx_ep_ff == 2'(e)) begin
          cfg_ff[e][`UEFC_B_TOGGLE] <= !cfg_ff[e][`UEFC_B_TOGGLE];
        end
      end
      if (wr_cfg) begin
        cfg_ff[sel_ff] <= bus.reg_wdata;
      end
    end
  end

  // Hardware set wins over a firmware clear in the same cycle
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      flag_ff <= '0;
    end else begin
      for (int e = 0; e < NEP; e++) begin
        for (int b = 0; b < 2; b++) begin
          if (commit && rx_ep_ff == 2'(e) && rx_bank_ff == 1'(b)) begin
            flag_ff[e][b] <= 1'b1;
          end else if (clr_bank[b] && sel_ff == 2'(e)) begin
            flag_ff[e][b] <= 1'b0;
          end
        end
      end
    end
  end

  // Bank numbers are untouched by FIFO reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      fill_ff <= '0;
      rdb_ff <= '0;
    end else begin
      if (commit && pp_mode[rx_ep_ff]) begin
        fill_ff[rx_ep_ff] <= !rx_bank_ff;
      end
      if (pp_mode[sel_ff] && clr_bank[rdb_ff[sel_ff]]) begin
        rdb_ff[sel_ff] <= !rdb_ff[sel_ff];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
      fptr_ff <= '0;
    end else begin
      for (int e = 0; e < NEP; e++) begin
        if (freset_ff[e]) begin
          cnt_ff[e] <= '0;
          fptr_ff[e] <= 4'h0;
        end else begin
          if (commit && rx_ep_ff == 2'(e)) begin
            cnt_ff[e][rx_bank_ff] <= rcnt_ff;
          end
          if (sel_ff == 2'(e) && (|clr_bank)) begin
            fptr_ff[e] <= 4'h0;
          end else if (sel_ff == 2'(e) && (rd_data || wr_data)) begin
            fptr_ff[e] <= fptr_ff[e] + 4'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rx_state_ff == uefc_pkg::UEFC_RX_RECV && rx_byte_valid_in && wptr_ff < 5'(DEPTH)) begin
      mem[{rx_ep_ff, rx_bank_ff, wptr_ff[3:0]}] <= rx_byte_in;
    end
    if (wr_data) begin
      mem[fw_idx] <= bus.reg_wdata;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_state_ff <= uefc_pkg::UEFC_RX_IDLE;
      rx_ep_ff <= 2'h0;
      rx_bank_ff <= 1'b0;
      wptr_ff <= 5'h00;
      rcnt_ff <= 8'h00;
      hs_ack_ff <= 1'b0;
      hs_nak_ff <= 1'b0;
    end else begin
      hs_ack_ff <= 1'b0;
      hs_nak_ff <= 1'b0;
      case (rx_state_ff)
        uefc_pkg::UEFC_RX_IDLE: begin
          if (rx_start_in && clk_ok_ff) begin
            rx_ep_ff <= rx_ep_in;
            rx_bank_ff <= st_bank;
            wptr_ff <= 5'h00;
            rcnt_ff <= 8'h00;
            if (!st_en || !st_out_ok || freset_ff[rx_ep_in]) begin
              rx_state_ff <= uefc_pkg::UEFC_RX_DROP;
            end else if (st_busy) begin
              hs_nak_ff <= 1'b1;
              rx_state_ff <= uefc_pkg::UEFC_RX_DROP;
            end else begin
              rx_state_ff <= uefc_pkg::UEFC_RX_RECV;
            end
          end
        end
        uefc_pkg::UEFC_RX_RECV: begin
          if (rx_byte_valid_in) begin
            rcnt_ff <= rcnt_ff + 8'h01;
            if (wptr_ff < 5'(DEPTH)) begin
              wptr_ff <= wptr_ff + 5'h01;
            end
          end
          if (rx_end_in) begin
            hs_ack_ff <= rx_crc_ok_in;
            rx_state_ff <= uefc_pkg::UEFC_RX_IDLE;
          end
        end
        uefc_pkg::UEFC_RX_DROP: begin
          if (rx_end_in) begin
            rx_state_ff <= uefc_pkg::UEFC_RX_IDLE;
          end
        end
        default: begin
          rx_state_ff <= uefc_pkg::UEFC_RX_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (bus.reg_addr == `UEFC_A_SELECT) begin
      rd_mux = {6'h00, sel_ff};
    end else if (bus.reg_addr == `UEFC_A_CONFIG) begin
      rd_mux = cfg_ff[sel_ff];
    end else if (bus.reg_addr == `UEFC_A_STATUS) begin
      rd_mux = {3'h0, rd_bank, 2'h0, flag_ff[sel_ff]};
    end else if (bus.reg_addr == `UEFC_A_DATA) begin
      rd_mux = mem[fw_idx];
    end else if (bus.reg_addr == `UEFC_A_COUNT) begin
      rd_mux = cnt_ff[sel_ff][rd_bank];
    end else if (bus.reg_addr == `UEFC_A_FRESET) begin
      rd_mux = freset_ff;
    end else if (bus.reg_addr == `UEFC_A_IRQEN) begin
      rd_mux = {4'h0, irqen_ff};
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else begin
      if (bus.reg_rd) begin
        rdata_ff <= rd_mux;
      end
      irq_ff <= |(irqen_ff & {|flag_ff[3], |flag_ff[2], |flag_ff[1], |flag_ff[0]});
    end
  end

  assign bus.reg_rdata = rdata_ff;
  assign hs_ack_out = hs_ack_ff;
  assign hs_nak_out = hs_nak_ff;
  assign rx_irq_out = irq_ff;
endmodule

// file: design/uefc_firmware.sv
`timescale 1ns/1ps
`include "uefc_defs.svh"
module uefc_firmware (
  input wire logic clock_in,
  input wire logic rst_in,
  uefc_if.fw bus,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic [1:0] cmd_ep_in,
  input wire logic [7:0] cmd_cfg_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic rd_valid_out,
  output logic [7:0] rd_byte_out,
  output logic done_out
);
  localparam logic [7:0] DEPTH8 = 8'(`UEFC_DEPTH);

  uefc_pkg::uefc_fw_state_t st_ff;
  uefc_pkg::uefc_op_t op_ff;
  logic [1:0] ep_ff;
  logic [7:0] cfg_ff;
  logic [7:0] data_ff;
  logic bank_ff;
  logic [7:0] left_ff;
  logic [7:0] wcnt_ff;
  logic [3:0] ien_ff;
  logic rd_valid_ff;
  logic [7:0] rd_byte_ff;
  logic [7:0] cnt_lim;

  assign cnt_lim = (bus.reg_rdata > DEPTH8) ? DEPTH8 : bus.reg_rdata;

  always_comb begin
    bus.reg_wr = 1'b0;
    bus.reg_rd = 1'b0;
    bus.reg_addr = `UEFC_A_SELECT;
    bus.reg_wdata = 8'h00;
    case (st_ff)
      uefc_pkg::UEFC_FW_IDLE: begin
        bus.reg_wr = cmd_valid_in;
        bus.reg_wdata = {6'h00, cmd_ep_in};
      end
      uefc_pkg::UEFC_FW_OP: begin
        case (op_ff)
          uefc_pkg::UEFC_OP_CONFIG: begin
            bus.reg_wr = 1'b1;
            bus.reg_addr = `UEFC_A_CONFIG;
            bus.reg_wdata = (ep_ff == 2'h0) ? `UEFC_CFG_CONTROL : cfg_ff;
          end
          uefc_pkg::UEFC_OP_RESET: begin
            bus.reg_wr = 1'b1;
            bus.reg_addr = `UEFC_A_FRESET;
            bus.reg_wdata = 8'h01 << ep_ff;
          end
          uefc_pkg::UEFC_OP_WRITE: begin
            bus.reg_wr = wcnt_ff < DEPTH8;
            bus.reg_addr = `UEFC_A_DATA;
            bus.reg_wdata = data_ff;
          end
          default: begin
            bus.reg_rd = 1'b1;
            bus.reg_addr = `UEFC_A_STATUS;
          end
        endcase
      end
      uefc_pkg::UEFC_FW_RST0: begin
        bus.reg_wr = 1'b1;
        bus.reg_addr = `UEFC_A_FRESET;
      end
      uefc_pkg::UEFC_FW_STAT: begin
        bus.reg_rd = bus.reg_rdata[bus.reg_rdata[`UEFC_B_RDBANK]];
        bus.reg_addr = `UEFC_A_COUNT;
      end
      uefc_pkg::UEFC_FW_CNT: begin
        bus.reg_rd = cnt_lim != 8'h00;
        bus.reg_addr = `UEFC_A_DATA;
      end
      uefc_pkg::UEFC_FW_DATA: begin
        bus.reg_rd = left_ff != 8'h00;
        bus.reg_addr = `UEFC_A_DATA;
      end
      uefc_pkg::UEFC_FW_CLR: begin
        bus.reg_wr = 1'b1;
        bus.reg_addr = `UEFC_A_STATUS;
        bus.reg_wdata = bank_ff ? 8'h01 : 8'h02;
      end
      uefc_pkg::UEFC_FW_DONE: begin
        // Interrupt enables follow each endpoint's enable bit
        bus.reg_wr = op_ff == uefc_pkg::UEFC_OP_CONFIG;
        bus.reg_addr = `UEFC_A_IRQEN;
        bus.reg_wdata = {4'h0, ien_ff};
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_ff <= uefc_pkg::UEFC_FW_IDLE;
      op_ff <= uefc_pkg::UEFC_OP_CONFIG;
      ep_ff <= 2'h0;
      cfg_ff <= 8'h00;
      data_ff <= 8'h00;
      bank_ff <= 1'b0;
      left_ff <= 8'h00;
      wcnt_ff <= 8'h00;
      ien_ff <= 4'h0;
      rd_valid_ff <= 1'b0;
      rd_byte_ff <= 8'h00;
    end else begin
      rd_valid_ff <= 1'b0;
      case (st_ff)
        uefc_pkg::UEFC_FW_IDLE: begin
          if (cmd_valid_in) begin
            op_ff <= uefc_pkg::uefc_op_t'(cmd_op_in);
            ep_ff <= cmd_ep_in;
            cfg_ff <= cmd_cfg_in;
            data_ff <= cmd_data_in;
            st_ff <= uefc_pkg::UEFC_FW_OP;
          end
        end
        uefc_pkg::UEFC_FW_OP: begin
          if (op_ff == uefc_pkg::UEFC_OP_CONFIG) begin
            ien_ff[ep_ff] <= bus.reg_wdata[`UEFC_B_ENABLE];
          end
          if (op_ff == uefc_pkg::UEFC_OP_RESET) begin
            st_ff <= uefc_pkg::UEFC_FW_RST0;
          end else if (op_ff == uefc_pkg::UEFC_OP_DRAIN) begin
            st_ff <= uefc_pkg::UEFC_FW_STAT;
          end else begin
            if (op_ff == uefc_pkg::UEFC_OP_WRITE && wcnt_ff < DEPTH8) begin
              wcnt_ff <= wcnt_ff + 8'h01;
            end
            st_ff <= uefc_pkg::UEFC_FW_DONE;
          end
        end
        uefc_pkg::UEFC_FW_RST0: begin
          wcnt_ff <= 8'h00;
          st_ff <= uefc_pkg::UEFC_FW_DONE;
        end
        uefc_pkg::UEFC_FW_STAT: begin
          bank_ff <= bus.reg_rdata[`UEFC_B_RDBANK];
          if (bus.reg_rdata[bus.reg_rdata[`UEFC_B_RDBANK]]) begin
            st_ff <= uefc_pkg::UEFC_FW_CNT;
          end else begin
            st_ff <= uefc_pkg::UEFC_FW_DONE;
          end
        end
        uefc_pkg::UEFC_FW_CNT: begin
          left_ff <= (cnt_lim == 8'h00) ? 8'h00 : cnt_lim - 8'h01;
          st_ff <= (cnt_lim == 8'h00) ? uefc_pkg::UEFC_FW_CLR : uefc_pkg::UEFC_FW_DATA;
        end
        uefc_pkg::UEFC_FW_DATA: begin
          rd_valid_ff <= 1'b1;
          rd_byte_ff <= bus.reg_rdata;
          if (left_ff != 8'h00) begin
            left_ff <= left_ff - 8'h01;
          end else begin
            st_ff <= uefc_pkg::UEFC_FW_CLR;
          end
        end
        uefc_pkg::UEFC_FW_CLR: begin
          st_ff <= uefc_pkg::UEFC_FW_DONE;
        end
        default: begin
          st_ff <= uefc_pkg::UEFC_FW_IDLE;
        end
      endcase
    end
  end

  assign cmd_ready_out = st_ff == uefc_pkg::UEFC_FW_IDLE;
  assign done_out = st_ff == uefc_pkg::UEFC_FW_DONE;
  assign rd_valid_out = rd_valid_ff;
  assign rd_byte_out = rd_byte_ff;
endmodule

// file: shared/uefc_defs.svh
`ifndef UEFC_DEFS_SVH
`define UEFC_DEFS_SVH

// Endpoint count, FIFO depth per bank and which endpoints are two-bank
`define UEFC_NEP 4
`define UEFC_DEPTH 16
`define UEFC_PP_MASK 4'h6

// Register addresses on the firmware port
`define UEFC_A_SELECT 3'h0
`define UEFC_A_CONFIG 3'h1
`define UEFC_A_STATUS 3'h2
`define UEFC_A_DATA 3'h3
`define UEFC_A_COUNT 3'h4
`define UEFC_A_FRESET 3'h5
`define UEFC_A_IRQEN 3'h6

// Config register fields
`define UEFC_B_ENABLE 7
`define UEFC_B_TOGGLE 3
`define UEFC_B_DIR 2
`define UEFC_CFG_CONTROL 8'h80
`define UEFC_CFG_RESET 8'h00

// Status register fields
`define UEFC_B_RX0 0
`define UEFC_B_RX1 1
`define UEFC_B_RDBANK 4

`endif

// file: shared/uefc_if.sv
`timescale 1ns/1ps
interface uefc_if;
  logic reg_wr;
  logic reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;

  modport dev (input reg_wr, input reg_rd, input reg_addr, input reg_wdata, output reg_rdata);
  modport fw (output reg_wr, output reg_rd, output reg_addr, output reg_wdata, input reg_rdata);
endinterface

// file: shared/uefc_pkg.sv
package uefc_pkg;
  typedef enum logic [1:0] {
    UEFC_TYPE_CONTROL = 2'h0,
    UEFC_TYPE_ISO = 2'h1,
    UEFC_TYPE_BULK = 2'h2,
    UEFC_TYPE_INTR = 2'h3
  } uefc_type_t;

  typedef enum logic [1:0] {
    UEFC_OP_CONFIG = 2'h0,
    UEFC_OP_RESET = 2'h1,
    UEFC_OP_DRAIN = 2'h2,
    UEFC_OP_WRITE = 2'h3
  } uefc_op_t;

  typedef enum {UEFC_RX_IDLE, UEFC_RX_RECV, UEFC_RX_DROP} uefc_rx_state_t;

  typedef enum {UEFC_FW_IDLE, UEFC_FW_OP, UEFC_FW_RST0, UEFC_FW_STAT, UEFC_FW_CNT,
                UEFC_FW_DATA, UEFC_FW_CLR, UEFC_FW_DONE} uefc_fw_state_t;
endpackage

// file: tb/uefc_chk.sv
`timescale 1ns/1ps
`include "uefc_defs.svh"
module uefc_chk (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic cmd_ready_out,
  input wire logic done_out,
  input wire logic rx_start_in,
  input wire logic rx_end_in,
  input wire logic rx_crc_ok_in,
  input wire logic hs_ack_out,
  input wire logic hs_nak_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic taken;
  assign taken = cmd_valid_in && cmd_ready_out;
  sequence s_cfg_wr;
    reg_wr && reg_addr == `UEFC_A_CONFIG;
  endsequence
  // Reset bit raised, then the whole register cleared on the next access
  sequence s_reset_pair;
    (reg_wr && reg_addr == `UEFC_A_FRESET && reg_wdata != 8'h00)
      ##1 (reg_wr && reg_addr == `UEFC_A_FRESET && reg_wdata == 8'h00);
  endsequence
  a_select_on_take: assert property (taken |-> reg_wr && reg_addr == `UEFC_A_SELECT)
    else $error("select write missing at command start");
  a_config_then_done: assert property (taken && cmd_op_in == 2'h0 |=> s_cfg_wr ##1 done_out)
    else $error("config command sequence wrong");
  a_reset_set_clear: assert property (taken && cmd_op_in == 2'h1 |=> s_reset_pair ##1 done_out)
    else $error("fifo reset sequence wrong");
  a_drain_status_first: assert property (taken && cmd_op_in == 2'h2 |=> reg_rd && reg_addr == `UEFC_A_STATUS)
    else $error("drain did not read status first");
  a_data_after_count: assert property (reg_rd && reg_addr == `UEFC_A_DATA |->
    $past(reg_rd) && ($past(reg_addr) == `UEFC_A_COUNT || $past(reg_addr) == `UEFC_A_DATA))
    else $error("data read before count read");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_ack_has_cause: assert property (hs_ack_out |-> $past(rx_end_in) && $past(rx_crc_ok_in))
    else $error("ack without good packet end");
  a_bad_crc_quiet: assert property (rx_end_in && !rx_crc_ok_in |=> !hs_ack_out)
    else $error("ack after bad crc");
  a_nak_has_cause: assert property (hs_nak_out |-> $past(rx_start_in) && !hs_ack_out)
    else $error("nak without packet start");
endmodule

// file: tb/usb_endpoint_fifo_control_tb_top.sv
`timescale 1ns/1ps
module usb_endpoint_fifo_control_tb_top;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_ok_in = 1'b1;
  logic rx_start_in = 1'b0;
  logic [1:0] rx_ep_in = 2'h0;
  logic rx_byte_valid_in = 1'b0;
  logic [7:0] rx_byte_in = 8'h00;
  logic rx_end_in = 1'b0;
  logic rx_crc_ok_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  logic [1:0] cmd_op_in = 2'h0;
  logic [1:0] cmd_ep_in = 2'h0;
  logic [7:0] cmd_cfg_in = 8'h00;
  logic [7:0] cmd_data_in = 8'h00;
  logic hs_ack_out, hs_nak_out, rx_irq_out, cmd_ready_out, rd_valid_out, done_out;
  logic [7:0] rd_byte_out;
  logic [7:0] got_q[$];
  logic [7:0] cfg_tab [4] = '{8'h80, 8'h84, 8'h81, 8'h83};
  int error_cnt = 0;
  int samples_checked = 0;
  int cycle_cnt = 0;
  int ack_cnt = 0;
  int nak_cnt = 0;

  uefc_if bus_if();
  uefc_device uefc_device_inst (.clock_in(clock_in), .rst_in(rst_in), .bus(bus_if), .clk_ok_in(clk_ok_in),
    .rx_start_in(rx_start_in), .rx_ep_in(rx_ep_in), .rx_byte_valid_in(rx_byte_valid_in),
    .rx_byte_in(rx_byte_in), .rx_end_in(rx_end_in), .rx_crc_ok_in(rx_crc_ok_in),
    .hs_ack_out(hs_ack_out), .hs_nak_out(hs_nak_out), .rx_irq_out(rx_irq_out));
  uefc_firmware uefc_firmware_inst (.clock_in(clock_in), .rst_in(rst_in), .bus(bus_if),
    .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in), .cmd_ep_in(cmd_ep_in), .cmd_cfg_in(cmd_cfg_in),
    .cmd_data_in(cmd_data_in), .cmd_ready_out(cmd_ready_out), .rd_valid_out(rd_valid_out),
    .rd_byte_out(rd_byte_out), .done_out(done_out));
  uefc_chk uefc_chk_inst (.clock_in(clock_in), .rst_in(rst_in), .reg_wr(bus_if.reg_wr), .reg_rd(bus_if.reg_rd),
    .reg_addr(bus_if.reg_addr), .reg_wdata(bus_if.reg_wdata), .reg_rdata(bus_if.reg_rdata),
    .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in), .cmd_ready_out(cmd_ready_out), .done_out(done_out),
    .rx_start_in(rx_start_in), .rx_end_in(rx_end_in), .rx_crc_ok_in(rx_crc_ok_in),
    .hs_ack_out(hs_ack_out), .hs_nak_out(hs_nak_out));

  always #5 clock_in = ~clock_in;

  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Handshake pulses and drained bytes are collected where they are settled
  always @(negedge clock_in) begin
    if (hs_ack_out === 1'b1) ack_cnt++;
    if (hs_nak_out === 1'b1) nak_cnt++;
    if (rd_valid_out === 1'b1) got_q.push_back(rd_byte_out);
    cycle_cnt++;
    if (cycle_cnt == 20000) begin
      error_cnt++;
      $display("unexpected at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  task chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task cmd(input logic [1:0] op, input logic [1:0] ep, input logic [7:0] cfg);
    int i;
    @(negedge clock_in);
    cmd_valid_in = 1'b1;
    cmd_op_in = op;
    cmd_ep_in = ep;
    cmd_cfg_in = cfg;
    i = 0;
    while (cmd_ready_out !== 1'b1 && i < 100) begin
      @(negedge clock_in);
      i++;
    end
    @(negedge clock_in);
    cmd_valid_in = 1'b0;
    i = 0;
    while (done_out !== 1'b1 && i < 100) begin
      @(negedge clock_in);
      i++;
    end
    chk(done_out === 1'b1, "command never completed");
  endtask

  task setup(input logic [1:0] ep, input logic [7:0] cfg);
    cmd(2'h0, ep, cfg);
    cmd(2'h1, ep, 8'h00);
  endtask

  task drain(input logic [1:0] ep, input int n, input logic [7:0] first);
    got_q.delete();
    cmd(2'h2, ep, 8'h00);
    chk(got_q.size() == n, "drained byte count");
    for (int i = 0; i < got_q.size() && i < n; i++) begin
      chk(got_q[i] === first + 8'(i), "drained byte value");
    end
  endtask

  task pkt(input logic [1:0] ep, input int n, input logic [7:0] first, input logic crc, input int eack,
           input int enak);
    int a0;
    int k0;
    a0 = ack_cnt;
    k0 = nak_cnt;
    @(negedge clock_in);
    rx_start_in = 1'b1;
    rx_ep_in = ep;
    for (int i = 0; i < n; i++) begin
      @(negedge clock_in);
      rx_start_in = 1'b0;
      rx_byte_valid_in = 1'b1;
      rx_byte_in = first + 8'(i);
    end
    @(negedge clock_in);
    rx_start_in = 1'b0;
    rx_byte_valid_in = 1'b0;
    rx_byte_in = ~rx_byte_in;
    rx_end_in = 1'b1;
    rx_crc_ok_in = crc;
    @(negedge clock_in);
    rx_end_in = 1'b0;
    rx_crc_ok_in = 1'b0;
    repeat (3) @(negedge clock_in);
    chk(ack_cnt - a0 == eack, "ack count");
    chk(nak_cnt - k0 == enak, "nak count");
  endtask

  initial begin
    repeat (16) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clock_in);
    pkt(2'h2, 2, 8'h10, 1'b1, 0, 0);
    setup(2'h3, 8'h82);
    pkt(2'h3, 3, 8'h20, 1'b1, 1, 0);
    chk(rx_irq_out === 1'b1, "no interrupt after packet");
    pkt(2'h3, 2, 8'h40, 1'b1, 0, 1);
    drain(2'h3, 3, 8'h20);
    @(negedge clock_in);
    chk(rx_irq_out === 1'b0, "interrupt still high after drain");
    pkt(2'h3, 0, 8'h00, 1'b1, 1, 0);
    drain(2'h3, 0, 8'h00);
    pkt(2'h3, 20, 8'h60, 1'b1, 1, 0);
    drain(2'h3, 16, 8'h60);
    pkt(2'h3, 2, 8'h90, 1'b0, 0, 0);
    drain(2'h3, 0, 8'h00);
    pkt(2'h3, 3, 8'ha0, 1'b1, 1, 0);
    cmd(2'h1, 2'h3, 8'h00);
    drain(2'h3, 0, 8'h00);
    setup(2'h1, 8'h82);
    pkt(2'h1, 2, 8'h30, 1'b1, 1, 0);
    pkt(2'h1, 3, 8'h50, 1'b1, 1, 0);
    pkt(2'h1, 1, 8'h70, 1'b1, 0, 1);
    drain(2'h1, 2, 8'h30);
    drain(2'h1, 3, 8'h50);
    pkt(2'h1, 1, 8'h70, 1'b1, 1, 0);
    drain(2'h1, 1, 8'h70);
    setup(2'h1, 8'h80);
    pkt(2'h1, 1, 8'hb0, 1'b1, 1, 0);
    pkt(2'h1, 1, 8'hb1, 1'b1, 0, 1);
    drain(2'h1, 1, 8'hb0);
    for (int j = 0; j < 4; j++) begin
      setup(2'h3, cfg_tab[j]);
      pkt(2'h3, 1, 8'hc0 + 8'(j), 1'b1, 1, 0);
      drain(2'h3, 1, 8'hc0 + 8'(j));
    end
    setup(2'h3, 8'h80);
    pkt(2'h3, 16, 8'he0, 1'b1, 1, 0);
    cmd_data_in = 8'hf0;
    cmd(2'h3, 2'h3, 8'h00);
    cmd_data_in = 8'hf1;
    cmd(2'h3, 2'h3, 8'h00);
    drain(2'h3, 16, 8'he2);
    setup(2'h3, 8'h86);
    pkt(2'h3, 1, 8'hd0, 1'b1, 0, 0);
    print_verdict();
  end
endmodule
